// ==== src/map_pkg.sv ====
// Package for the memory access port packing block.
// Assumes one 50 MHz clock domain shared by all users.
package map_pkg;
    // Register select codes on the access port request
    localparam logic [1:0] CTRL_IDX   = 2'h0;
    localparam logic [1:0] ADDR_IDX   = 2'h1;
    localparam logic [1:0] DATA_IDX   = 2'h3;
    // Control word field positions
    localparam int         SIZE_LO    = 0;
    localparam int         INC_LO     = 4;
    localparam int         SPI_BIT    = 23;
    localparam int         PROT_LO    = 24;
    localparam int         GATE_BIT   = 31;
    // Access size codes
    localparam logic [2:0] SZ_BYTE    = 3'h0;
    localparam logic [2:0] SZ_HALF    = 3'h1;
    localparam logic [2:0] SZ_WORD    = 3'h2;
    // Address step mode codes
    localparam logic [1:0] INC_OFF    = 2'h0;
    localparam logic [1:0] INC_PACKED = 2'h2;
    // Reset values: privileged data attributes, gate enabled
    localparam logic [6:0] PROT_RST   = 7'h03;
    localparam logic       GATE_RST   = 1'h1;
    // Per-size address steps and packed beat counts
    localparam logic [31:0] STEP_BYTE = 32'h1;
    localparam logic [31:0] STEP_HALF = 32'h2;
    localparam logic [31:0] STEP_WORD = 32'h4;
    localparam logic [2:0] BEATS_BYTE = 3'h4;
    localparam logic [2:0] BEATS_HALF = 3'h2;
    localparam logic [2:0] BEATS_ONE  = 3'h1;
    // Transaction count that means a single word
    localparam logic [11:0] TRN_ONE   = 12'h1;

    // One memory bus access
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [2:0]  size;
        logic [6:0]  prot;
        logic        write;
    } map_bus_t;

    // Sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_SLV} map_state_t;

    // Address step for one access of a size
    function automatic logic [31:0] size_step(input logic [2:0] sz);
        case (sz)
            SZ_BYTE: size_step = STEP_BYTE;
            SZ_HALF: size_step = STEP_HALF;
            default: size_step = STEP_WORD;
        endcase
    endfunction

    // Byte lanes used by one access, little-endian
    function automatic logic [3:0] lane_mask(input logic [2:0] sz, input logic [1:0] a);
        case (sz)
            SZ_BYTE: lane_mask = 4'h1 << a;
            SZ_HALF: lane_mask = a[1] ? 4'hc : 4'h3;
            default: lane_mask = 4'hf;
        endcase
    endfunction
endpackage

// ==== src/map_packer.sv ====
// Memory access port sequencer: splits data word accesses into packed bus accesses.
// Assumes the debug port holds a request for one cycle and waits for o_ap_ack,
// and the memory bus answers each held o_bus_req with a one-cycle i_bus_ack.
`timescale 1ns/1ps

// Functional notes
// - Step mode packed code enables packing
// - Size code selects byte or halfword
// - Packed word size gives one access
// - Byte writes use lane from address
// - Address advances by size after success, held when step mode is off
// - Halfword reads land in addressed half
// - Read completes only when word filled
// - Bus error halts sequence, reports error
// - Compare only on fully packed word
// - Counted transactions each fully packed
// - Gate bit reads zero when unused
// - Slave accesses muxed, address bit forced
// - Gate bit enables slave port
// - Gate bit drives gating output otherwise
// - Attribute field drives bus protection
// - Secure debug indicator readable
module map_packer #(
    parameter bit HAS_SLAVE_PORT = 1'b1,  // Slave memory port fitted
    parameter bit HAS_GATE       = 1'b0   // Gating output fitted
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ap_req,
    input  wire logic              i_ap_write,
    input  wire logic              i_ap_cmp,
    input  wire logic [1:0]        i_ap_idx,
    input  wire logic [31:0]       i_ap_wdata,
    input  wire logic [11:0]       i_ap_cnt,
    output logic                   o_ap_ack,
    output logic                   o_ap_err,
    output logic [31:0]            o_ap_rdata,
    output logic                   o_cmp_valid,
    output logic                   o_cmp_equal,
    output logic                   o_bus_req,
    output map_pkg::map_bus_t      o_bus,
    input  wire logic              i_bus_ack,
    input  wire logic              i_bus_err,
    input  wire logic [31:0]       i_bus_rdata,
    input  wire logic              i_sp_req,
    input  map_pkg::map_bus_t      i_sp,
    output logic                   o_sp_ack,
    output logic                   o_sp_err,
    output logic [31:0]            o_sp_rdata,
    input  wire logic              i_secure_debug_en,
    output logic                   o_software_debug_gate_signal
);
    import map_pkg::*;

    localparam bit GATE_USED = HAS_SLAVE_PORT | HAS_GATE;

    map_state_t  st_q;       // Sequencer state
    logic [2:0]  size_q;     // Control word size field
    logic [1:0]  inc_q;      // Control word step mode
    logic [6:0]  prot_q;     // Bus protection attributes
    logic        gate_q;     // Software debug gate bit
    logic [31:0] xaddr_q;    // Transfer address
    logic [31:0] dword_q;    // Data word being packed
    logic [31:0] cmp_q;      // Pushed compare value
    logic [2:0]  beats_q;    // Accesses left in this word
    logic [11:0] trn_q;      // Word transactions left
    logic        wr_q;       // Current word is a write
    logic        pcmp_q;     // Current word is a pushed compare
    logic [3:0]  mask;       // Lanes of the current access
    logic [31:0] rd_word;    // Word with this read merged in
    logic [31:0] xaddr_next; // Address after a good access
    logic [2:0]  beats_new;  // Accesses per word at start
    logic [31:0] ctrl_rd;    // Control word read value
    logic        last_beat;  // Good ack closes the word

    // Lanes follow the low address bits of each access
    assign mask = lane_mask(size_q, xaddr_q[1:0]);

    // Read merge, one generate entry per byte lane
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign rd_word[8*g +: 8] = mask[g] ? i_bus_rdata[8*g +: 8] : dword_q[8*g +: 8];
        end
    endgenerate

    assign xaddr_next = (inc_q == INC_OFF) ? xaddr_q : xaddr_q + size_step(size_q);
    assign beats_new = (inc_q != INC_PACKED) ? BEATS_ONE :
                       (size_q == SZ_BYTE)   ? BEATS_BYTE :
                       (size_q == SZ_HALF)   ? BEATS_HALF : BEATS_ONE;
    assign last_beat = (st_q == ST_BUS) && i_bus_ack && !i_bus_err && (beats_q == BEATS_ONE);

    // gate bit reads zero when unused
    always_comb begin
        ctrl_rd                  = '0;
        ctrl_rd[SIZE_LO +: 3]    = size_q;
        ctrl_rd[INC_LO +: 2]     = inc_q;
        ctrl_rd[SPI_BIT]         = i_secure_debug_en;
        ctrl_rd[PROT_LO +: 7]    = prot_q;
        ctrl_rd[GATE_BIT]        = GATE_USED & gate_q;
    end

    // Control word fields, written only when idle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            size_q <= SZ_WORD;
            inc_q  <= INC_OFF;
            prot_q <= PROT_RST;
            gate_q <= GATE_RST;
        end else if (st_q == ST_IDLE && i_ap_req && i_ap_write && i_ap_idx == CTRL_IDX) begin
            size_q <= i_ap_wdata[SIZE_LO +: 3];
            inc_q  <= i_ap_wdata[INC_LO +: 2];
            prot_q <= i_ap_wdata[PROT_LO +: 7];
            gate_q <= i_ap_wdata[GATE_BIT];
        end
    end

    // gating output follows the gate bit with HAS_GATE set, held low when a slave port is fitted
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_software_debug_gate_signal <= HAS_GATE & !HAS_SLAVE_PORT & GATE_RST;
        end else begin
            o_software_debug_gate_signal <= HAS_GATE & !HAS_SLAVE_PORT & gate_q;
        end
    end

    // Transfer address: software writes, hardware steps
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            xaddr_q <= '0;
        end else if (st_q == ST_IDLE && i_ap_req && i_ap_write && i_ap_idx == ADDR_IDX) begin
            // debugger may clear bit 31 here
            xaddr_q <= i_ap_wdata;
        end else if (st_q == ST_BUS && i_bus_ack && !i_bus_err) begin
            xaddr_q <= xaddr_next;
        end
    end

    // Data word: loaded by writes, packed by reads
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dword_q <= '0;
            cmp_q   <= '0;
        end else if (st_q == ST_IDLE && i_ap_req && i_ap_idx == DATA_IDX) begin
            dword_q <= i_ap_write ? i_ap_wdata : '0;
            cmp_q   <= i_ap_wdata;
        end else if (st_q == ST_BUS && i_bus_ack && !i_bus_err && !wr_q) begin
            dword_q <= last_beat ? '0 : rd_word;  // Next word starts clean
        end
    end

    // Sequencer, bus master and answers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q        <= ST_IDLE;
            beats_q     <= BEATS_ONE;
            trn_q       <= TRN_ONE;
            wr_q        <= 1'b0;
            pcmp_q      <= 1'b0;
            o_bus_req   <= 1'b0;
            o_bus       <= '0;
            o_ap_ack    <= 1'b0;
            o_ap_err    <= 1'b0;
            o_ap_rdata  <= '0;
            o_cmp_valid <= 1'b0;
            o_cmp_equal <= 1'b0;
            o_sp_ack    <= 1'b0;
            o_sp_err    <= 1'b0;
            o_sp_rdata  <= '0;
        end else begin
            // Answers are one-cycle pulses by default
            o_ap_ack    <= 1'b0;
            o_ap_err    <= 1'b0;
            o_cmp_valid <= 1'b0;
            o_sp_ack    <= 1'b0;
            o_sp_err    <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (i_ap_req && i_ap_idx == DATA_IDX) begin
                        // Start a word; count zero means one word
                        wr_q       <= i_ap_write & !i_ap_cmp;
                        pcmp_q     <= i_ap_cmp;
                        beats_q    <= beats_new;
                        trn_q      <= (i_ap_cnt == '0) ? TRN_ONE : i_ap_cnt;
                        o_bus      <= '{addr: xaddr_q, wdata: i_ap_wdata, size: size_q,
                                        prot: prot_q, write: i_ap_write & !i_ap_cmp};
                        o_bus_req  <= 1'b1;
                        st_q       <= ST_BUS;
                    end else if (i_ap_req) begin
                        // Register access answers next cycle
                        o_ap_ack   <= 1'b1;
                        o_ap_err   <= (i_ap_idx != CTRL_IDX) && (i_ap_idx != ADDR_IDX);
                        o_ap_rdata <= i_ap_write ? '0 : (i_ap_idx == CTRL_IDX) ? ctrl_rd :
                                      (i_ap_idx == ADDR_IDX) ? xaddr_q : '0;
                    end else if (i_sp_req && !o_sp_ack && HAS_SLAVE_PORT && gate_q) begin
                        // slave access, bit 31 forced low
                        // A request still up while its answer stands is the old one
                        o_bus      <= '{addr: {1'b0, i_sp.addr[30:0]}, wdata: i_sp.wdata,
                                        size: i_sp.size, prot: i_sp.prot, write: i_sp.write};
                        o_bus_req  <= 1'b1;
                        st_q       <= ST_SLV;
                    end else if (i_sp_req && !o_sp_ack) begin
                        o_sp_ack   <= 1'b1;
                        o_sp_err   <= 1'b1;
                    end
                end
                ST_BUS: begin
                    if (i_bus_ack && i_bus_err) begin
                        o_bus_req  <= 1'b0;
                        o_ap_ack   <= 1'b1;
                        o_ap_err   <= 1'b1;
                        o_ap_rdata <= '0;
                        st_q       <= ST_IDLE;
                    end else if (i_bus_ack && beats_q != BEATS_ONE) begin
                        // next beat, lane from next address
                        beats_q    <= beats_q - BEATS_ONE;
                        o_bus.addr <= xaddr_next;
                    end else if (i_bus_ack) begin
                        o_cmp_valid <= pcmp_q;
                        o_cmp_equal <= pcmp_q & (rd_word == cmp_q);
                        if (trn_q == TRN_ONE) begin
                            o_bus_req  <= 1'b0;
                            o_ap_ack   <= 1'b1;
                            o_ap_rdata <= wr_q ? '0 : rd_word;
                            st_q       <= ST_IDLE;
                        end else begin
                            trn_q      <= trn_q - TRN_ONE;
                            beats_q    <= beats_new;
                            o_bus.addr <= xaddr_next;
                        end
                    end
                end
                ST_SLV: begin
                    if (i_bus_ack) begin
                        // Slave answer passes straight back
                        o_bus_req  <= 1'b0;
                        o_sp_ack   <= 1'b1;
                        o_sp_err   <= i_bus_err;
                        o_sp_rdata <= i_bus_rdata;
                        st_q       <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Checks on the sequencer
    pack_beats_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == ST_IDLE && i_ap_req && i_ap_idx == DATA_IDX && inc_q == INC_PACKED && size_q == SZ_BYTE)
        |=> (beats_q == BEATS_BYTE)) else $error("packed byte word not four beats");
    size_field_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == ST_BUS) |-> (o_bus.size == size_q)) else $error("bus size differs from size field");
    word_single_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == ST_IDLE && i_ap_req && i_ap_idx == DATA_IDX && size_q == SZ_WORD)
        |=> (beats_q == BEATS_ONE)) else $error("word size not one access");
    write_data_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == ST_BUS && o_bus.write) |-> (o_bus.wdata == dword_q)) else $error("write lanes lost");
    addr_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == ST_BUS && i_bus_ack && !i_bus_err && inc_q == INC_PACKED && size_q == SZ_HALF)
        |=> (xaddr_q == $past(xaddr_q) + STEP_HALF)) else $error("halfword step not two");
    half_lane_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == ST_BUS && i_bus_ack && !i_bus_err && !wr_q && size_q == SZ_HALF && xaddr_q[1]
         && beats_q != BEATS_ONE) |=> (dword_q[31:16] == $past(i_bus_rdata[31:16])))
        else $error("upper half not packed");
    read_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == ST_BUS && i_bus_ack && !i_bus_err && beats_q != BEATS_ONE) |=> !o_ap_ack)
        else $error("answer before word filled");
    err_halt_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == ST_BUS && i_bus_ack && i_bus_err) |=> (o_ap_ack && o_ap_err && !o_bus_req))
        else $error("error did not halt sequence");
    cmp_whole_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_cmp_valid |-> $past(last_beat)) else $error("compare on partial word");
    slave_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == ST_SLV && o_bus_req) |-> !o_bus.addr[31]) else $error("slave address bit 31 set");
    gate_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !GATE_USED |-> !ctrl_rd[GATE_BIT]) else $error("unused gate bit reads one");

    packed_byte_c: cover property (@(posedge i_clk) disable iff (i_rst)
        last_beat && inc_q == INC_PACKED && size_q == SZ_BYTE);
    bus_error_c:   cover property (@(posedge i_clk) disable iff (i_rst)
        st_q == ST_BUS && i_bus_ack && i_bus_err);
    counted_c:     cover property (@(posedge i_clk) disable iff (i_rst)
        last_beat && trn_q != TRN_ONE);
    slave_c:       cover property (@(posedge i_clk) disable iff (i_rst) o_sp_ack && !o_sp_err);
endmodule

// ==== verification/map_mem_model.sv ====
// Memory bus partner: byte store with wait states and one failing address.
// Assumes the block holds each access and its fields until the ack cycle.
`timescale 1ns/1ps
module map_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_req,
    input  map_pkg::map_bus_t i_bus,
    input  wire logic [3:0]  i_wait,
    input  wire logic [31:0] i_err_addr,
    output logic             o_ack,
    output logic             o_err,
    output logic [31:0]      o_rdata
);
    import map_pkg::*;
    logic [7:0] mem [256];  // Byte store, wraps at 256
    logic [3:0] cnt_q;      // Wait states served so far
    logic       hit;        // Lane belongs to this access
    // Known pattern so reads of untouched bytes are defined
    initial begin
        for (int k = 0; k < 256; k++) begin
            mem[k] = 8'(k);
        end
    end
    // One access at a time; idle read lanes toggle so stale data never matches
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ack   <= 1'b0;
            o_err   <= 1'b0;
            cnt_q   <= 4'h0;
            o_rdata <= 32'h0;
        end else if (i_req && !o_ack && cnt_q == i_wait) begin
            o_ack <= 1'b1;
            o_err <= (i_bus.addr == i_err_addr);
            cnt_q <= 4'h0;
            for (int k = 0; k < 4; k++) begin
                hit = (i_bus.size == SZ_BYTE) ? (2'(k) == i_bus.addr[1:0]) :
                      (i_bus.size == SZ_HALF) ? (k / 2 == int'(i_bus.addr[1])) : 1'b1;
                o_rdata[8*k+:8] <= mem[{i_bus.addr[7:2], 2'(k)}];
                // Failed accesses leave memory alone
                if (i_bus.write && hit && i_bus.addr != i_err_addr) begin
                    mem[{i_bus.addr[7:2], 2'(k)}] <= i_bus.wdata[8*k+:8];
                end
            end
        end else begin
            o_ack   <= 1'b0;
            o_err   <= 1'b0;
            cnt_q   <= (i_req && !o_ack) ? cnt_q + 4'h1 : 4'h0;
            o_rdata <= ~o_rdata;
        end
    end
endmodule

// ==== verification/tb.sv ====
// Bench for the packing sequencer: register accesses, packed traffic, slave port.
// Assumes map_mem_model on the memory bus and a 50 MHz clock.
`timescale 1ns/1ps
module tb;
    import map_pkg::*;
    logic        i_clk, i_rst, req, wr, cmp, sp_req, sec, ack, err, er, cmp_eq;
    logic        ap_ack, ap_err, cmp_valid, cmp_equal, bus_req, sp_ack, sp_err, gate, gate2;
    logic [1:0]  idx;
    logic [3:0]  wait_n;
    logic [11:0] cnt;
    logic [31:0] wdata, rd, err_addr, rdat, ap_rdata, sp_rdata;
    map_bus_t    bus, sp;
    logic [31:0] addr_q[$];  // Addresses of acknowledged beats
    int          n_mismatch, n_checks, n_cmp;

    map_packer #(.HAS_SLAVE_PORT(1'b1), .HAS_GATE(1'b0)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_ap_req(req), .i_ap_write(wr), .i_ap_cmp(cmp),
        .i_ap_idx(idx), .i_ap_wdata(wdata), .i_ap_cnt(cnt), .o_ap_ack(ap_ack),
        .o_ap_err(ap_err), .o_ap_rdata(ap_rdata), .o_cmp_valid(cmp_valid),
        .o_cmp_equal(cmp_equal), .o_bus_req(bus_req), .o_bus(bus), .i_bus_ack(ack),
        .i_bus_err(err), .i_bus_rdata(rdat), .i_sp_req(sp_req), .i_sp(sp),
        .o_sp_ack(sp_ack), .o_sp_err(sp_err), .o_sp_rdata(sp_rdata),
        .i_secure_debug_en(sec), .o_software_debug_gate_signal(gate));
    map_mem_model MEM (
        .i_clk(i_clk), .i_rst(i_rst), .i_req(bus_req), .i_bus(bus), .i_wait(wait_n),
        .i_err_addr(err_addr), .o_ack(ack), .o_err(err), .o_rdata(rdat));
    // Gating-output variant in lockstep with DUT: same requests, same bus answers
    map_packer #(.HAS_SLAVE_PORT(1'b0), .HAS_GATE(1'b1)) DUT_GATE (
        .i_clk(i_clk), .i_rst(i_rst), .i_ap_req(req), .i_ap_write(wr), .i_ap_cmp(cmp),
        .i_ap_idx(idx), .i_ap_wdata(wdata), .i_ap_cnt(cnt), .o_ap_ack(), .o_ap_err(),
        .o_ap_rdata(), .o_cmp_valid(), .o_cmp_equal(), .o_bus_req(), .o_bus(), .i_bus_ack(ack),
        .i_bus_err(err), .i_bus_rdata(rdat), .i_sp_req(sp_req), .i_sp(sp), .o_sp_ack(),
        .o_sp_err(), .o_sp_rdata(), .i_secure_debug_en(sec), .o_software_debug_gate_signal(gate2));

    // Clock, 20 ns period
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // Beat and compare monitor; reads settled values of the closing cycle
    always @(posedge i_clk) begin
        if (bus_req === 1'b1 && ack === 1'b1) addr_q.push_back(bus.addr);
        if (cmp_valid === 1'b1) begin
            n_cmp++;
            cmp_eq = cmp_equal;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Beat count and increasing address walk, then clear the log
    task automatic chk_walk(input logic [31:0] base, input int step, input int n);
        chk(32'(addr_q.size()), 32'(n));
        for (int k = 0; k < n && k < addr_q.size(); k++) chk(addr_q[k], base + 32'(k * step));
        addr_q.delete();
    endtask
    // One request pulse, fields held until the ack edge
    task automatic ap(input logic [1:0] i, input logic w, input logic c, input logic [31:0] d,
                      input logic [11:0] n);
        int k;
        @(posedge i_clk);
        req   <= 1'b1;
        wr    <= w;
        cmp   <= c;
        idx   <= i;
        wdata <= d;
        cnt   <= n;
        @(posedge i_clk);
        req <= 1'b0;
        for (k = 0; k < 400; k++) begin
            @(posedge i_clk);
            if (ap_ack === 1'b1) break;
        end
        if (k == 400) chk(32'h0, 32'h1);
        rd = ap_rdata;
        er = ap_err;
        // Let the monitor log this edge before the caller checks its counts
        @(negedge i_clk);
    endtask
    // Slave access held until its answer is seen
    task automatic slv(input logic [31:0] a);
        int k;
        @(posedge i_clk);
        sp_req <= 1'b1;
        sp     <= '{addr: a, wdata: 32'h5a5a5a5a, size: SZ_WORD, prot: PROT_RST, write: 1'b1};
        for (k = 0; k < 400; k++) begin
            @(posedge i_clk);
            if (sp_ack === 1'b1) break;
        end
        if (k == 400) chk(32'h0, 32'h1);
        er = sp_err;
        rd = sp_rdata;
        sp_req <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard, well past the expected run
    initial begin
        #(20 * 20000);
        n_mismatch++;
        print_verdict();
    end
    // Main sequence
    initial begin
        {req, wr, cmp, sp_req, idx, cnt, wdata, sp} = '0;
        sec = 1'b1;
        wait_n = 4'h0;
        err_addr = 32'hffffffff;
        i_rst = 1'b1;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        ap(CTRL_IDX, 1'b0, 1'b0, 32'h0, 12'h0);
        chk(rd, 32'h83800002);
        chk(32'(gate2), 32'h1);
        // Packed bytes from address 2
        ap(CTRL_IDX, 1'b1, 1'b0, 32'h83000020, 12'h0);
        ap(ADDR_IDX, 1'b1, 1'b0, 32'h2, 12'h0);
        addr_q.delete();
        ap(DATA_IDX, 1'b1, 1'b0, 32'h44332211, 12'h1);
        chk_walk(32'h2, 1, 4);
        ap(ADDR_IDX, 1'b0, 1'b0, 32'h0, 12'h0);
        chk(rd, 32'h6);
        // Packed halfword read back with slow memory
        wait_n <= 4'h2;
        ap(CTRL_IDX, 1'b1, 1'b0, 32'h83000021, 12'h0);
        ap(ADDR_IDX, 1'b1, 1'b0, 32'h2, 12'h0);
        ap(DATA_IDX, 1'b0, 1'b0, 32'h0, 12'h1);
        chk(rd, 32'h44332211);
        chk_walk(32'h2, 2, 2);
        // Pushed compare, match then miss, one result per word
        n_cmp = 0;
        ap(ADDR_IDX, 1'b1, 1'b0, 32'h2, 12'h0);
        ap(DATA_IDX, 1'b1, 1'b1, 32'h44332211, 12'h1);
        chk(32'(n_cmp), 32'h1);
        chk(32'(cmp_eq), 32'h1);
        ap(ADDR_IDX, 1'b1, 1'b0, 32'h2, 12'h0);
        ap(DATA_IDX, 1'b1, 1'b1, 32'h44332210, 12'h1);
        chk(32'(cmp_eq), 32'h0);
        addr_q.delete();
        wait_n <= 4'h0;
        // Packed word size gives one beat
        ap(CTRL_IDX, 1'b1, 1'b0, 32'h83000022, 12'h0);
        ap(ADDR_IDX, 1'b1, 1'b0, 32'h20, 12'h0);
        ap(DATA_IDX, 1'b1, 1'b0, 32'ha5a5a5a5, 12'h1);
        chk_walk(32'h20, 4, 1);
        // Two counted words in packed bytes
        ap(CTRL_IDX, 1'b1, 1'b0, 32'h83000020, 12'h0);
        ap(ADDR_IDX, 1'b1, 1'b0, 32'h8, 12'h0);
        ap(DATA_IDX, 1'b1, 1'b0, 32'hdeadbeef, 12'h2);
        chk_walk(32'h8, 1, 8);
        ap(ADDR_IDX, 1'b0, 1'b0, 32'h0, 12'h0);
        chk(rd, 32'h10);
        // Error on the last byte halts and reports
        err_addr <= 32'hb;
        ap(ADDR_IDX, 1'b1, 1'b0, 32'h8, 12'h0);
        ap(DATA_IDX, 1'b1, 1'b0, 32'h01020304, 12'h1);
        chk(32'(er), 32'h1);
        chk_walk(32'h8, 1, 4);
        ap(ADDR_IDX, 1'b0, 1'b0, 32'h0, 12'h0);
        chk(rd, 32'hb);
        err_addr <= 32'hffffffff;
        ap(2'h2, 1'b0, 1'b0, 32'h0, 12'h0);
        chk(32'(er), 32'h1);
        // Slave port: address bit 31 cleared, gate disables
        slv(32'h80000040);
        chk(32'(er), 32'h0);
        chk(rd, 32'h43424140);
        chk(addr_q[0], 32'h40);
        addr_q.delete();
        ap(CTRL_IDX, 1'b1, 1'b0, 32'h03000022, 12'h0);
        slv(32'h80000040);
        chk(32'(er), 32'h1);
        chk(32'(addr_q.size()), 32'h0);
        sec <= 1'b0;
        ap(CTRL_IDX, 1'b0, 1'b0, 32'h0, 12'h0);
        chk(rd, 32'h03000022);
        chk(32'(gate), 32'h0);
        chk(32'(gate2), 32'h0);
        print_verdict();
    end
endmodule
